/* hw/tscr_pkg.sv */
// Purpose: constants and types for touch status and calibration registers
// Assumes: 16-bit register port, printed offsets used as addresses
// Notes:   one state struct per module, reset value held here
package tscr_pkg;
   // ************************************************************
   // widths, offsets and fields
   // ************************************************************
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 16;
   localparam int          NUM_CH        = 13;
   localparam int          TRIM_W        = 8;
   localparam logic [11:0] OFS_MASK_LO   = 12'h043;
   localparam logic [11:0] OFS_MASK_HI   = 12'h044;
   localparam logic [11:0] OFS_FLAGS_LO  = 12'h045;
   localparam logic [11:0] OFS_FLAGS_HI  = 12'h046;
   localparam logic [11:0] OFS_SLIDER    = 12'h04B;
   localparam logic [11:0] OFS_TRIM_CFG  = 12'h04E;
   localparam logic [11:0] OFS_ITER_CAP  = 12'h050;
   localparam logic [11:0] OFS_CLR_LO    = 12'h0F0;
   localparam logic [11:0] OFS_CLR_HI    = 12'h0F1;
   localparam int          GPIO_BIT      = 15;
   localparam int          SLD_EVT_BIT   = 7;
   localparam int          CAL_DONE_BIT  = 14;
   localparam int          DRIFT_OFF_BIT = 13;
   localparam int          STEP_LSB      = 0;
   localparam int          CAP_LSB       = 0;
   localparam logic [15:0] LO_VALID      = 16'h011E;
   localparam logic [15:0] HI_VALID      = 16'h833F;
   localparam logic [4:0]  POS_MAX       = 5'h0A;
   // ************************************************************
   // reset values and timing
   // ************************************************************
   localparam logic [15:0] MASK_HI_RST   = 16'h0300;
   localparam logic [3:0]  TRIM_STEP_RST = 4'h2;
   localparam logic [3:0]  ADAPT_START   = 4'h8;
   localparam logic [7:0]  TRIM_RST      = 8'h80;
   localparam int          CLK_PERIOD_PS = 5000;
   localparam int          STEP_PERIOD_NS = 80;
   localparam int          STEP_CYCLES   = (STEP_PERIOD_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic [2:0] {
      CAL_RUN   = 3'b001,
      CAL_TRACK = 3'b010,
      CAL_HOLD  = 3'b100
   } tscr_cal_type;

   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } tscr_bus_type;

   typedef struct packed {
      logic       touch;
      logic       move;
      logic       dir;
      logic [4:0] pos;
   } tscr_slider_type;

   typedef struct packed {
      logic [15:0]  rdata;
      logic         sync1;
      logic         sync2;
      logic         gpio_q;
      logic [12:0]  touch_q;
      logic [15:0]  flags_lo;
      logic [15:0]  flags_hi;
      logic [15:0]  mask_lo;
      logic [15:0]  mask_hi;
      logic [15:0]  slider;
      logic         drift_off;
      logic [3:0]   trim_step;
      logic [3:0]   step_cur;
      logic [7:0]   iter_cap;
      logic [7:0]   iter;
      logic [7:0]   trim;
      tscr_cal_type cal_st;
      logic         cal_done;
      logic         last_dn;
      logic [15:0]  tick_cnt;
      logic         tick;
      logic         irq_n;
   } tscr_state_type;

   localparam tscr_state_type STATE_RST = '{
      rdata: 16'h0000, sync1: 1'b0, sync2: 1'b0, gpio_q: 1'b0,
      touch_q: 13'h0000, flags_lo: 16'h0000, flags_hi: 16'h0000,
      mask_lo: 16'h0000, mask_hi: MASK_HI_RST, slider: 16'h0000,
      drift_off: 1'b0, trim_step: TRIM_STEP_RST, step_cur: ADAPT_START,
      iter_cap: 8'h00, iter: 8'h00, trim: TRIM_RST, cal_st: CAL_RUN,
      cal_done: 1'b0, last_dn: 1'b0, tick_cnt: 16'h0000, tick: 1'b0,
      irq_n: 1'b1};
endpackage : tscr_pkg

/* hw/tscr_regs.sv */
// Purpose: touch flags, slider report, trim calibration and drift control
// Assumes: front-end inputs on i_core_clk except the gpio pin
// Notes:   read data valid only in the cycle after the read strobe
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A gpio input event sets bit 15 of the upper touch flag register.
// - That event is only taken while the shared pin is configured as input.
// - Touch flags show which channels were touched, in the split bit layout.
// - Bit 7 of the slider status is the slider event and ignores host writes.
// - Bit 6 is high while slider movement and direction are reported.
// - Bit 5 is the read-only direction, 1 for high/right/clockwise.
// - Bits 4:0 hold a position from 1 to 10 while the slider is touched.
// - Position reads zero when channels are not set up as a slider.
// - Bit 14 of trim config is 0 during calibration and 1 once it is done.
// - Drift tracking stops while bit 13 is set and runs while it is clear.
// - A zero trim step selects adaptive trim tracking during calibration.
// - A nonzero trim step moves the trim by that much per step, saturating at 00 and FF.
// - Calibration ends when iterations reach the cap; zero means no cap.
// - A channel raises the interrupt only when its mask bit is set.
module tscr_regs #(
   parameter int STEP_CYCLES = tscr_pkg::STEP_CYCLES
) (
   input  wire logic                     i_core_clk,      // core clock
   input  wire logic                     i_rst,           // sync reset
   input  wire tscr_pkg::tscr_bus_type   i_bus,           // register port
   output logic [15:0]                   o_rdata,         // read data
   input  wire logic [12:0]              i_touch_det,     // per-channel touch
   input  wire logic                     i_gpio_pin,      // async gpio pin
   input  wire logic                     i_gpio_is_input, // pin set as input
   input  wire logic                     i_slider_mode,   // slider configured
   input  wire tscr_pkg::tscr_slider_type i_slider,       // slider report
   input  wire logic                     i_cal_start,     // start calibration
   input  wire logic                     i_cal_at_target, // measurement locked
   input  wire logic                     i_cal_higher,    // trim must go down
   input  wire logic                     i_drift_up,      // ambient drift up
   input  wire logic                     i_drift_dn,      // ambient drift down
   output logic [7:0]                    o_trim_cap,      // trim capacitor
   output logic                          o_cal_done,      // calibration done
   output logic                          o_host_irq_n     // interrupt, low
);
   import tscr_pkg::*;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] map_lo(input logic [12:0] c);
      map_lo = {7'h00, c[4], 3'h0, c[3:0], 1'b0};
   endfunction : map_lo

   function automatic logic [15:0] map_hi(input logic [12:0] c);
      map_hi = {6'h00, c[12:11], 2'h0, c[10:5]};
   endfunction : map_hi

   function automatic logic hit(input tscr_bus_type b, input logic [11:0] ofs);
      hit = (b.addr == ofs);
   endfunction : hit

   function automatic logic [7:0] trim_move(input logic [7:0] t,
                                            input logic [3:0] a,
                                            input logic dn);
      if (dn) begin
         trim_move = (t < {4'h0, a}) ? 8'h00 : t - {4'h0, a};
      end else begin
         trim_move = (t > (8'hFF - {4'h0, a})) ? 8'hFF : t + {4'h0, a};
      end
   endfunction : trim_move

   tscr_state_type r_reg;
   tscr_state_type r_next;
   logic [12:0]    rise;
   logic           gpio_evt;
   logic [15:0]    clr_lo;
   logic [15:0]    clr_hi;
   logic [3:0]     amt;
   logic           touched;
   logic           cap_hit;
   logic [15:0]    rd_val;

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      r_next = r_reg;
      // step divider, one-cycle tick
      r_next.tick = 1'b0;
      if (r_reg.tick_cnt == 16'(STEP_CYCLES - 1)) begin
         r_next.tick_cnt = 16'h0000;
         r_next.tick     = 1'b1;
      end else begin
         r_next.tick_cnt = r_reg.tick_cnt + 16'h0001;
      end

      // gpio pin synchroniser and edge
      r_next.sync1  = i_gpio_pin;
      r_next.sync2  = r_reg.sync1;
      r_next.gpio_q = r_reg.sync2;
      gpio_evt = r_reg.sync2 & ~r_reg.gpio_q & i_gpio_is_input;

      // sticky touch flags, set beats clear
      rise = i_touch_det & ~r_reg.touch_q;
      r_next.touch_q = i_touch_det;
      clr_lo = (i_bus.wr && hit(i_bus, OFS_CLR_LO)) ? i_bus.wdata : 16'h0000;
      clr_hi = (i_bus.wr && hit(i_bus, OFS_CLR_HI)) ? i_bus.wdata : 16'h0000;
      r_next.flags_lo = ((r_reg.flags_lo & ~clr_lo) | map_lo(rise)) & LO_VALID;
      r_next.flags_hi = ((r_reg.flags_hi & ~clr_hi) | map_hi(rise)) & HI_VALID;
      if (gpio_evt) begin
         r_next.flags_hi[GPIO_BIT] = 1'b1;
      end

      // slider status follows the front end, host writes ignored
      touched = i_slider_mode & i_slider.touch;
      r_next.slider = 16'h0000;
      r_next.slider[SLD_EVT_BIT]     = touched;
      r_next.slider[SLD_EVT_BIT - 1] = touched & i_slider.move;
      r_next.slider[SLD_EVT_BIT - 2] = touched & i_slider.move & i_slider.dir;
      if (touched && i_slider.pos != 5'h00 && i_slider.pos <= POS_MAX) begin
         r_next.slider[4:0] = i_slider.pos;
      end  // else stays zero

      // host writes, only defined bits stored
      if (i_bus.wr) begin
         if (hit(i_bus, OFS_MASK_LO)) begin
            r_next.mask_lo = i_bus.wdata & LO_VALID;
         end
         if (hit(i_bus, OFS_MASK_HI)) begin
            r_next.mask_hi = i_bus.wdata & HI_VALID;
         end
         if (hit(i_bus, OFS_TRIM_CFG)) begin
            r_next.drift_off = i_bus.wdata[DRIFT_OFF_BIT];
            r_next.trim_step = i_bus.wdata[STEP_LSB +: 4];
         end
         if (hit(i_bus, OFS_ITER_CAP)) begin
            r_next.iter_cap = i_bus.wdata[CAP_LSB +: 8];
         end
      end

      // calibration and drift tracking
      amt = (r_reg.trim_step != 4'h0) ? r_reg.trim_step : r_reg.step_cur;
      cap_hit = (r_reg.iter_cap != 8'h00) && (r_reg.iter >= r_reg.iter_cap);
      case (r_reg.cal_st)
         CAL_RUN: begin
            if (r_reg.tick) begin
               if (cap_hit || i_cal_at_target) begin
                  r_next.cal_st = r_reg.drift_off ? CAL_HOLD : CAL_TRACK;
               end else begin
                  r_next.trim    = trim_move(r_reg.trim, amt, i_cal_higher);
                  r_next.last_dn = i_cal_higher;
                  if (r_reg.iter != 8'hFF) begin
                     r_next.iter = r_reg.iter + 8'h01;
                  end
                  // adaptive: halve the step on each reversal while it is above 1
                  if (r_reg.iter != 8'h00 && i_cal_higher != r_reg.last_dn &&
                      r_reg.step_cur > 4'h1) begin
                     r_next.step_cur = r_reg.step_cur >> 1;
                  end
               end
            end
         end
         CAL_TRACK: begin
            if (r_reg.drift_off) begin
               r_next.cal_st = CAL_HOLD;
            end else if (r_reg.tick && (i_drift_up ^ i_drift_dn)) begin
               r_next.trim = trim_move(r_reg.trim, 4'h1, i_drift_dn);
            end
         end
         CAL_HOLD: begin
            if (!r_reg.drift_off) begin
               r_next.cal_st = CAL_TRACK;
            end
         end
         default: begin
            r_next.cal_st = CAL_RUN;
         end
      endcase
      if (i_cal_start) begin
         r_next.cal_st   = CAL_RUN;
         r_next.iter     = 8'h00;
         r_next.step_cur = ADAPT_START;
      end
      r_next.cal_done = (r_next.cal_st != CAL_RUN);

      // read mux, data only in the cycle after the strobe
      rd_val = 16'h0000;
      case (i_bus.addr)
         OFS_FLAGS_LO: rd_val = r_reg.flags_lo;
         OFS_FLAGS_HI: rd_val = r_reg.flags_hi;
         OFS_MASK_LO:  rd_val = r_reg.mask_lo;
         OFS_MASK_HI:  rd_val = r_reg.mask_hi;
         OFS_SLIDER:   rd_val = r_reg.slider;
         OFS_TRIM_CFG: begin
            rd_val[CAL_DONE_BIT]     = r_reg.cal_done;
            rd_val[DRIFT_OFF_BIT]    = r_reg.drift_off;
            rd_val[STEP_LSB +: 4]    = r_reg.trim_step;
         end
         OFS_ITER_CAP: rd_val[CAP_LSB +: 8] = r_reg.iter_cap;
         default:      rd_val = 16'h0000;
      endcase
      r_next.rdata = i_bus.rd ? rd_val : 16'h0000;

      // interrupt pin tracks the flags it is registered with
      r_next.irq_n = ~(|(r_next.flags_lo & r_next.mask_lo) |
                       |(r_next.flags_hi & r_next.mask_hi) |
                       r_next.slider[SLD_EVT_BIT]);
   end

   // ************************************************************
   // state register and outputs
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         r_reg <= STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_rdata      = r_reg.rdata;
   assign o_trim_cap   = r_reg.trim;
   assign o_cal_done   = r_reg.cal_done;
   assign o_host_irq_n = r_reg.irq_n;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_gpio_sets: assert property (gpio_evt |=> r_reg.flags_hi[GPIO_BIT])
      else $error("gpio event not flagged");
   a_gpio_gated: assert property (
      $rose(r_reg.flags_hi[GPIO_BIT]) |-> $past(i_gpio_is_input))
      else $error("gpio flag set while pin not input");
   a_touch_flag: assert property (
      (i_touch_det[4] && !r_reg.touch_q[4]) |=> r_reg.flags_lo[8] && r_reg.flags_hi[7:6] == 2'h0)
      else $error("channel 4 touch not in low bit 8");
   a_slider_ro: assert property (
      (i_bus.wr && hit(i_bus, OFS_SLIDER) && !i_slider.touch) |=> !r_reg.slider[SLD_EVT_BIT])
      else $error("host write changed slider event");
   a_pos_range: assert property (
      r_reg.slider[4:0] != 5'h00 |-> r_reg.slider[4:0] <= POS_MAX && r_reg.slider[SLD_EVT_BIT])
      else $error("slider position out of range");
   a_pos_zero: assert property (!i_slider_mode |=> r_reg.slider == 16'h0000)
      else $error("slider report while not slider");
   a_done_read: assert property (
      (i_bus.rd && hit(i_bus, OFS_TRIM_CFG)) |=> o_rdata[CAL_DONE_BIT] == $past(o_cal_done))
      else $error("calibration done bit wrong");
   a_drift_hold: assert property (
      (r_reg.cal_st == CAL_HOLD && !i_cal_start) |=> $stable(r_reg.trim))
      else $error("trim moved with drift tracking off");
   a_fixed_step: assert property (
      (r_reg.cal_st == CAL_RUN && r_reg.tick && r_reg.trim_step != 4'h0 && !cap_hit &&
       !i_cal_at_target && !i_cal_start && r_reg.trim > 8'h10 && r_reg.trim < 8'hEF)
      |=> (r_reg.trim == $past(r_reg.trim) + 8'($past(r_reg.trim_step)) ||
           r_reg.trim == $past(r_reg.trim) - 8'($past(r_reg.trim_step))))
      else $error("trim step size wrong");
   a_cap_ends: assert property (
      (r_reg.cal_st == CAL_RUN && r_reg.tick && cap_hit && !i_cal_start)
      |=> r_reg.cal_st != CAL_RUN && o_cal_done)
      else $error("calibration ran past cap");
   a_irq_masked: assert property (
      (r_reg.mask_lo == 16'h0000 && r_reg.mask_hi == 16'h0000 && !r_reg.slider[SLD_EVT_BIT])
      |-> o_host_irq_n)
      else $error("interrupt from masked flag");
   a_irq_slider: assert property ($rose(r_reg.slider[SLD_EVT_BIT]) |-> !o_host_irq_n)
      else $error("slider event did not pull interrupt");
   a_unused_zero: assert property (
      (i_bus.rd && hit(i_bus, OFS_FLAGS_HI)) |=> (o_rdata & ~HI_VALID) == 16'h0000)
      else $error("unused bits read nonzero");
   // movement flag follows the movement report only while touched
   a_move_valid: assert property (
      (i_slider_mode && i_slider.touch) |=> r_reg.slider[6] == $past(i_slider.move))
      else $error("movement flag wrong");
   a_move_idle: assert property (!i_slider.move |=> !r_reg.slider[6])
      else $error("movement flag without movement");
   // direction reported while movement is active
   a_dir_report: assert property (
      (i_slider_mode && i_slider.touch && i_slider.move) |=> r_reg.slider[5] == $past(i_slider.dir))
      else $error("slider direction wrong");
   // adaptive tracking always moves the trim while it is away from the rails
   a_adapt_step: assert property (
      (r_reg.cal_st == CAL_RUN && r_reg.tick && r_reg.trim_step == 4'h0 && !cap_hit &&
       !i_cal_at_target && !i_cal_start && r_reg.trim > 8'h10 && r_reg.trim < 8'hEF)
      |=> r_reg.trim != $past(r_reg.trim))
      else $error("adaptive step did not move trim");

   c_cal_finish: cover property (r_reg.cal_st == CAL_RUN ##1 r_reg.cal_st == CAL_TRACK);
   c_gpio_irq:   cover property (gpio_evt ##1 !o_host_irq_n);
   c_clear_flag: cover property (r_reg.flags_lo[1] ##1 !r_reg.flags_lo[1]);
   c_slider_mv:  cover property (r_reg.slider[6] && r_reg.slider[5]);
endmodule : tscr_regs

`default_nettype wire

/* tb/tscr_host_model.sv */
// Purpose: host processor model driving the register port
// Assumes: strobes taken at the next rising edge, read data valid one cycle later
// Notes:   released address and data show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module tscr_host_model (
   input  wire logic              i_core_clk, // core clock
   output var tscr_pkg::tscr_bus_type o_bus,  // register port request
   input  wire logic [15:0]       i_rdata     // registered read data
);
   import tscr_pkg::*;
   initial o_bus = '0;
   // ************************************************************
   // one-cycle write and read strobes
   // ************************************************************
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_core_clk);
      o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge i_core_clk);
      o_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_core_clk);
      o_bus <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
      #1 d = i_rdata;
   endtask : rd
endmodule : tscr_host_model
`default_nettype wire

/* tb/tscr_regs_tb_top.sv */
// Purpose: self-checking bench for the touch status and calibration registers
// Assumes: short calibration tick (2 cycles) for a brief run
// Notes:   front-end inputs driven by the bench, bus driven by the host model
`timescale 1ns/1ps
`default_nettype none
module tscr_regs_tb_top;
   import tscr_pkg::*;
   localparam int          BITPOS  [13] = '{1, 2, 3, 4, 8, 0, 1, 2, 3, 4, 5, 8, 9};
   localparam logic [11:0] RST_ADR [8]  = '{OFS_FLAGS_LO, OFS_FLAGS_HI, OFS_SLIDER,
      OFS_TRIM_CFG, OFS_ITER_CAP, OFS_MASK_HI, OFS_CLR_LO, 12'h100};
   localparam logic [15:0] RST_VAL [8]  = '{16'h0000, 16'h0000, 16'h0000, 16'h0002,
      16'h0000, 16'h0300, 16'h0000, 16'h0000};
   localparam logic [8:0]  SLD_IN  [5]  = '{9'h0E5, 9'h1E5, 9'h1EB, 9'h18A, 9'h181};
   localparam logic [15:0] SLD_EXP [5]  = '{16'h0000, 16'h00E5, 16'h00E0, 16'h008A, 16'h0081};
   logic            core_clk = 1'b0;
   logic            rst = 1'b1;
   tscr_bus_type    bus;
   logic [15:0]     rdata;
   logic [12:0]     touch_det = '0;
   logic            gpio_pin = 1'b0;
   logic            gpio_is_input = 1'b0;
   logic            slider_mode = 1'b0;
   tscr_slider_type slider = '0;
   logic            cal_start = 1'b0;
   logic            cal_at_target = 1'b1;
   logic            cal_higher = 1'b0;
   logic            drift_up = 1'b0;
   logic            drift_dn = 1'b0;
   logic [7:0]      trim_cap;
   logic            cal_done;
   logic            host_irq_n;
   logic [15:0]     d;
   logic            hi;
   int              error_cnt = 0;
   int              cmp_count = 0;
   int              cyc_cnt = 0;
   // clock and design
   always #2.5 core_clk = ~core_clk;
   tscr_host_model host (.i_core_clk(core_clk), .o_bus(bus), .i_rdata(rdata));
   tscr_regs #(.STEP_CYCLES(2)) dut (
      .i_core_clk(core_clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
      .i_touch_det(touch_det), .i_gpio_pin(gpio_pin), .i_gpio_is_input(gpio_is_input),
      .i_slider_mode(slider_mode), .i_slider(slider), .i_cal_start(cal_start),
      .i_cal_at_target(cal_at_target), .i_cal_higher(cal_higher), .i_drift_up(drift_up),
      .i_drift_dn(drift_dn), .o_trim_cap(trim_cap), .o_cal_done(cal_done),
      .o_host_irq_n(host_irq_n));
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // hang guard
   always @(posedge core_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      cyc(8);
      rst <= 1'b0;
      chk({8'h00, trim_cap}, 16'h0080);
      // reset values, unmapped and write-only places read zero
      for (int k = 0; k < 8; k++) begin
         host.rd(RST_ADR[k], d);
         chk(d & 16'hBFFF, RST_VAL[k]);
      end
      cyc(10);
      host.rd(OFS_TRIM_CFG, d);
      chk(d, 16'h4002);
      // unused bits ignore writes, read-only flags stay clear
      host.wr(OFS_ITER_CAP, 16'hFFFF);
      host.rd(OFS_ITER_CAP, d);
      chk(d, 16'h00FF);
      host.wr(OFS_FLAGS_LO, 16'hFFFF);
      host.rd(OFS_FLAGS_LO, d);
      chk(d, 16'h0000);
      host.wr(OFS_MASK_LO, 16'h0000);
      host.wr(OFS_MASK_HI, 16'h0000);
      // every channel: flag, masked interrupt, enabled interrupt, clear
      for (int c = 0; c < 13; c++) begin
         hi = (c > 4);
         @(posedge core_clk) touch_det <= 13'h0001 << c;
         cyc(2);
         host.rd(hi ? OFS_FLAGS_HI : OFS_FLAGS_LO, d);
         chk(d, 16'h0001 << BITPOS[c]);
         chk({15'h0000, host_irq_n}, 16'h0001);
         host.wr(hi ? OFS_MASK_HI : OFS_MASK_LO, 16'h0001 << BITPOS[c]);
         cyc(2);
         chk({15'h0000, host_irq_n}, 16'h0000);
         host.wr(hi ? OFS_CLR_HI : OFS_CLR_LO, 16'h0001 << BITPOS[c]);
         cyc(2);
         chk({15'h0000, host_irq_n}, 16'h0001);
         host.rd(hi ? OFS_FLAGS_HI : OFS_FLAGS_LO, d);
         chk(d, 16'h0000);
         host.wr(hi ? OFS_MASK_HI : OFS_MASK_LO, 16'h0000);
         @(posedge core_clk) touch_det <= '0;
      end
      // gpio edge dropped while the pin is not an input
      @(posedge core_clk) gpio_pin <= 1'b1;
      cyc(6);
      host.rd(OFS_FLAGS_HI, d);
      chk(d, 16'h0000);
      @(posedge core_clk) gpio_pin <= 1'b0;
      gpio_is_input <= 1'b1;
      cyc(6);
      @(posedge core_clk) gpio_pin <= 1'b1;
      cyc(6);
      host.rd(OFS_FLAGS_HI, d);
      chk(d, 16'h8000);
      host.wr(OFS_MASK_HI, 16'h8000);
      cyc(2);
      chk({15'h0000, host_irq_n}, 16'h0000);
      host.wr(OFS_CLR_HI, 16'h8000);
      cyc(2);
      chk({15'h0000, host_irq_n}, 16'h0001);
      // slider report cases, event pulls the interrupt low
      for (int k = 0; k < 5; k++) begin
         @(posedge core_clk) {slider_mode, slider} <= SLD_IN[k];
         cyc(2);
         host.rd(OFS_SLIDER, d);
         chk(d, SLD_EXP[k]);
         chk({15'h0000, host_irq_n}, {15'h0000, ~SLD_EXP[k][7]});
      end
      host.wr(OFS_SLIDER, 16'hFFFF);
      host.rd(OFS_SLIDER, d);
      chk(d, 16'h0081);
      @(posedge core_clk) {slider_mode, slider} <= 9'h000;
      // fixed trim step, iteration cap 4, drift tracking off
      host.wr(OFS_TRIM_CFG, 16'hFFF3);
      host.wr(OFS_ITER_CAP, 16'h0004);
      @(posedge core_clk) cal_at_target <= 1'b0;
      cal_start <= 1'b1;
      @(posedge core_clk) cal_start <= 1'b0;
      cyc(2);
      chk({15'h0000, cal_done}, 16'h0000);
      cyc(40);
      chk({8'h00, trim_cap}, 16'h008C);
      host.rd(OFS_TRIM_CFG, d);
      chk(d, 16'h6003);
      @(posedge core_clk) drift_up <= 1'b1;
      cyc(20);
      chk({8'h00, trim_cap}, 16'h008C);
      // adaptive step, one iteration downwards, then drift follows
      // drift input dropped first so tracking cannot move the trim before restart
      @(posedge core_clk) drift_up <= 1'b0;
      host.wr(OFS_TRIM_CFG, 16'h0000);
      host.wr(OFS_ITER_CAP, 16'h0001);
      @(posedge core_clk) cal_higher <= 1'b1;
      cal_start <= 1'b1;
      @(posedge core_clk) cal_start <= 1'b0;
      cyc(20);
      chk({8'h00, trim_cap}, 16'h0084);
      chk({15'h0000, cal_done}, 16'h0001);
      @(posedge core_clk) drift_dn <= 1'b1;
      cyc(20);
      chk({15'h0000, trim_cap < 8'h84}, 16'h0001);
      end_of_test();
   end
endmodule : tscr_regs_tb_top
`default_nettype wire
